// file: pkg/usb_psw_pkg.sv
package usb_psw_pkg;
	typedef enum logic [1:0] {
		P_SLEEP  = 2'b00,
		P_DETECT = 2'b01,
		P_ACTIVE = 2'b10,
		P_ERROR  = 2'b11
	} pwr_state_t;

	localparam int unsigned CLK_NS       = 10;
	localparam int unsigned T_SHORT_NS   = 1000;
	localparam int unsigned T_RISE_NS    = 20000;
	localparam int unsigned T_MASK_NS    = 1000000;
	localparam int unsigned SHORT_CYC    = T_SHORT_NS / CLK_NS;
	localparam int unsigned RISE_CYC     = (T_RISE_NS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned MASK_CYC     = (T_MASK_NS + CLK_NS - 1) / CLK_NS;

	// limit codes in strap order; values in mA for reference
	localparam logic [2:0] LIM_570  = 3'h0;
	localparam logic [2:0] LIM_1680 = 3'h4;
	localparam logic [2:0] LIM_2850 = 3'h7;

	localparam logic [3:0]  OFS_CONFIG  = 4'h0;
	localparam logic [3:0]  OFS_STATUS  = 4'h4;
	localparam logic [3:0]  OFS_LIMIT   = 4'h8;
	localparam logic [3:0]  OFS_CONTROL = 4'hc;
	localparam int unsigned CFG_KEEP    = 0;
	localparam int unsigned CFG_DETOPEN = 1;
	localparam int unsigned CFG_EMUOPEN = 2;
	localparam int unsigned CFG_LIM_LSB = 4;
	localparam logic [7:0]  CFG_RESET   = 8'h76;
	localparam int unsigned CTL_ERRCLR  = 0;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// file: verilog/event_timer.sv
`timescale 1ns/1ps
// counts consecutive cycles of run; done stays high from CYCLES reached until run drops
module event_timer #(
	parameter int unsigned CYCLES = 4
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic run,
	output logic      done
);
	localparam int unsigned W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] TOP = W'(CYCLES);

	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	// saturate so a long condition does not wrap and re-arm
	always_comb
	begin
		cnt_nxt = cnt_r;
		if (!run)
			cnt_nxt = '0;
		else if (cnt_r != TOP)
			cnt_nxt = cnt_r + W'(1);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			cnt_r <= '0;
		else
			cnt_r <= cnt_nxt;
	end

	assign done = (cnt_r == TOP);
endmodule

// file: verilog/usb_port_switch_control.sv
// Our own choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module usb_port_switch_control #(
	parameter int unsigned RISE_CYCLES = usb_psw_pkg::RISE_CYC,
	parameter int unsigned MASK_CYCLES = usb_psw_pkg::MASK_CYC
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic [3:0]  limit_and_comm_strap,
	input  wire logic        low_supply_ok,
	input  wire logic        port_power_enable_ctl,
	input  wire logic        sleep_req,
	input  wire logic        detect_enable,
	input  wire logic        attach_event,
	input  wire logic        removal_event,
	input  wire logic        emulating,
	input  wire logic        emu_profile_cdp,
	input  wire logic        dedicated_charger_emulation,
	input  wire logic        dcp_accepted,
	input  wire logic        cdp_mode,
	input  wire logic        profile_timeout_active,
	input  wire logic        vbus_discharging,
	input  wire logic        overcurrent,
	output logic             data_switch_close,
	output logic             port_switch_on,
	output logic [2:0]       current_limit_setting,
	output logic             constant_current_limiting,
	output logic             bypass_limit_sel,
	output logic             soft_start_active,
	output logic             current_clamp,
	output logic             comm_bus_mode,
	output logic             alert_n_out,
	output logic             alert_n_oe
);
	// register bus group
	logic        awready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
	logic [1:0]  bresp_nxt, rresp_nxt;
	logic [31:0] rdata_nxt;
	logic [7:0]  cfg_r, cfg_nxt;
	logic        errclr_r, errclr_nxt;
	logic [31:0] rd_word;

	// control group
	usb_psw_pkg::pwr_state_t state_r, state_nxt;
	logic       strap_done_r, strap_done_nxt;
	logic [2:0] hw_limit_r, hw_limit_nxt;
	logic       comm_nxt, en_d_r, attached_r, attached_nxt;
	logic       dsw_nxt, psw_nxt, cc_nxt, byp_nxt, ss_nxt, clamp_nxt, alert_nxt;
	logic [2:0] lim_nxt;
	logic       ss_trig, ss_done, ocp_done, mask_done, trip_evt;

	// ties programmed limit to the strap ceiling
	function automatic logic [2:0] cap_limit(input logic [2:0] req, input logic [2:0] ceil);
		cap_limit = (req > ceil) ? ceil : req;
	endfunction

	always_comb
	begin
		rd_word = 32'h0000_0000;
		case (araddr)
			usb_psw_pkg::OFS_CONFIG:  rd_word = {24'h00_0000, cfg_r};
			usb_psw_pkg::OFS_STATUS:  rd_word = {23'h00_0000, alert_n_oe, bypass_limit_sel,
				current_clamp, soft_start_active, constant_current_limiting,
				port_switch_on, data_switch_close, state_r};
			usb_psw_pkg::OFS_LIMIT:   rd_word = {23'h00_0000, comm_bus_mode, 1'b0,
				current_limit_setting, 1'b0, hw_limit_r};
			default:                  rd_word = 32'h0000_0000;
		endcase
	end

	// write ready pulses one cycle after both address and data are offered; read ready one cycle after the read address
	always_comb
	begin
		awready_nxt = 1'b0;
		bvalid_nxt  = bvalid && !bready;
		bresp_nxt   = bresp;
		cfg_nxt     = cfg_r;
		errclr_nxt  = 1'b0;
		arready_nxt = 1'b0;
		rvalid_nxt  = rvalid && !rready;
		rresp_nxt   = rresp;
		rdata_nxt   = rdata;
		if (awvalid && wvalid && !awready && !bvalid)
			awready_nxt = 1'b1;
		if (awready)
		begin
			bvalid_nxt = 1'b1;
			bresp_nxt  = usb_psw_pkg::RESP_OKAY;
			case (awaddr)
				usb_psw_pkg::OFS_CONFIG:
				begin
					if (wstrb[0])
						cfg_nxt = wdata[7:0];
				end
				usb_psw_pkg::OFS_CONTROL:
				begin
					errclr_nxt = wstrb[0] && wdata[usb_psw_pkg::CTL_ERRCLR];
				end
				usb_psw_pkg::OFS_STATUS, usb_psw_pkg::OFS_LIMIT: ;
				default: bresp_nxt = usb_psw_pkg::RESP_SLVERR;
			endcase
		end
		if (arvalid && !arready && !rvalid)
			arready_nxt = 1'b1;
		if (arready)
		begin
			rvalid_nxt = 1'b1;
			rdata_nxt  = rd_word;
			rresp_nxt  = (araddr == usb_psw_pkg::OFS_CONTROL || araddr[1:0] != 2'h0)
				? usb_psw_pkg::RESP_SLVERR : usb_psw_pkg::RESP_OKAY;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			awready  <= 1'b0;
			wready   <= 1'b0;
			bvalid   <= 1'b0;
			bresp    <= usb_psw_pkg::RESP_OKAY;
			arready  <= 1'b0;
			rvalid   <= 1'b0;
			rresp    <= usb_psw_pkg::RESP_OKAY;
			rdata    <= 32'h0000_0000;
			cfg_r    <= usb_psw_pkg::CFG_RESET;
			errclr_r <= 1'b0;
		end
		else
		begin
			awready  <= awready_nxt;
			wready   <= awready_nxt;
			bvalid   <= bvalid_nxt;
			bresp    <= bresp_nxt;
			arready  <= arready_nxt;
			rvalid   <= rvalid_nxt;
			rresp    <= rresp_nxt;
			rdata    <= rdata_nxt;
			cfg_r    <= cfg_nxt;
			errclr_r <= errclr_nxt;
		end
	end

	// soft start restarts on a new trigger by dropping run for one cycle
	assign ss_trig = (port_power_enable_ctl && !en_d_r) ||
		(state_r == usb_psw_pkg::P_DETECT && attach_event && port_power_enable_ctl);
	// trip limiting reacts at once; constant current waits out the mask time
	assign trip_evt = port_switch_on && overcurrent && !constant_current_limiting;

	event_timer #(.CYCLES(RISE_CYCLES)) u_soft (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (soft_start_active && !ss_trig),
		.done    (ss_done)
	);
	event_timer #(.CYCLES(MASK_CYCLES)) u_ocp (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (port_switch_on && overcurrent && constant_current_limiting),
		.done    (ocp_done)
	);
	event_timer #(.CYCLES(MASK_CYCLES)) u_mask (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (state_r == usb_psw_pkg::P_ERROR),
		.done    (mask_done)
	);

	// power state, strap capture and switch decisions
	always_comb
	begin
		state_nxt      = state_r;
		strap_done_nxt = 1'b1;
		hw_limit_nxt   = hw_limit_r;
		comm_nxt       = comm_bus_mode;
		if (!strap_done_r)
		begin
			hw_limit_nxt = limit_and_comm_strap[2:0];
			comm_nxt     = limit_and_comm_strap[3];
		end
		attached_nxt = (attached_r && !removal_event && state_r != usb_psw_pkg::P_SLEEP)
			|| attach_event;
		case (state_r)
			usb_psw_pkg::P_SLEEP:
				if (!sleep_req)
					state_nxt = (detect_enable && !attached_r) ? usb_psw_pkg::P_DETECT
						: usb_psw_pkg::P_ACTIVE;
			usb_psw_pkg::P_DETECT:
				if (sleep_req)
					state_nxt = usb_psw_pkg::P_SLEEP;
				else if (attach_event || !detect_enable)
					state_nxt = usb_psw_pkg::P_ACTIVE;
			usb_psw_pkg::P_ACTIVE:
				if (sleep_req)
					state_nxt = usb_psw_pkg::P_SLEEP;
				else if (detect_enable && !attached_r)
					state_nxt = usb_psw_pkg::P_DETECT;
			usb_psw_pkg::P_ERROR:
				if (errclr_r)
					state_nxt = usb_psw_pkg::P_SLEEP;
			default: state_nxt = usb_psw_pkg::P_SLEEP;
		endcase
		if (trip_evt || ocp_done)
			state_nxt = usb_psw_pkg::P_ERROR;

		dsw_nxt = low_supply_ok
			&& (state_r == usb_psw_pkg::P_ACTIVE
			|| (state_r == usb_psw_pkg::P_DETECT && !cfg_r[usb_psw_pkg::CFG_DETOPEN]))
			&& !(emulating && !emu_profile_cdp && cfg_r[usb_psw_pkg::CFG_EMUOPEN])
			&& !(dedicated_charger_emulation && !cfg_r[usb_psw_pkg::CFG_KEEP]);
		psw_nxt = state_r == usb_psw_pkg::P_ACTIVE && port_power_enable_ctl
			&& !vbus_discharging && !trip_evt && !ocp_done;
		lim_nxt = comm_bus_mode ? cap_limit(cfg_r[usb_psw_pkg::CFG_LIM_LSB +: 3], hw_limit_r)
			: hw_limit_r;
		// constant current only in the listed cases; trip otherwise
		cc_nxt  = cdp_mode || profile_timeout_active
			|| (dcp_accepted && lim_nxt < usb_psw_pkg::LIM_1680);
		byp_nxt = state_r == usb_psw_pkg::P_DETECT;
		ss_nxt  = ss_trig || (soft_start_active && !ss_done);
		clamp_nxt = port_switch_on && overcurrent;
		alert_nxt = mask_done;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state_r                   <= usb_psw_pkg::P_SLEEP;
			strap_done_r              <= 1'b0;
			hw_limit_r                <= usb_psw_pkg::LIM_570;
			comm_bus_mode             <= 1'b0;
			en_d_r                    <= 1'b0;
			attached_r                <= 1'b0;
			data_switch_close         <= 1'b0;
			port_switch_on            <= 1'b0;
			current_limit_setting     <= usb_psw_pkg::LIM_570;
			constant_current_limiting <= 1'b0;
			bypass_limit_sel          <= 1'b0;
			soft_start_active         <= 1'b0;
			current_clamp             <= 1'b0;
			alert_n_oe                <= 1'b0;
			alert_n_out               <= 1'b0;
		end
		else
		begin
			state_r                   <= state_nxt;
			strap_done_r              <= strap_done_nxt;
			hw_limit_r                <= hw_limit_nxt;
			comm_bus_mode             <= comm_nxt;
			en_d_r                    <= port_power_enable_ctl;
			attached_r                <= attached_nxt;
			data_switch_close         <= dsw_nxt;
			port_switch_on            <= psw_nxt;
			current_limit_setting     <= lim_nxt;
			constant_current_limiting <= cc_nxt;
			bypass_limit_sel          <= byp_nxt;
			soft_start_active         <= ss_nxt;
			current_clamp             <= clamp_nxt;
			alert_n_oe                <= alert_nxt;
			alert_n_out               <= 1'b0;
		end
	end

	// checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	logic [31:0] err_age_r;
	always_ff @(posedge aclk)
	begin
		if (!aresetn || state_r != usb_psw_pkg::P_ERROR)
			err_age_r <= 32'h0000_0000;
		else
			err_age_r <= err_age_r + 32'h0000_0001;
	end

	sequence s_trip;
		port_switch_on && overcurrent && !constant_current_limiting;
	endsequence
	sequence s_err_off;
		state_r == usb_psw_pkg::P_ERROR ##0 !port_switch_on;
	endsequence

	a_supply_low_open: assert property (!low_supply_ok |=> !data_switch_close)
		else $error("data switch closed with low supply");
	a_sleep_open: assert property (state_r == usb_psw_pkg::P_SLEEP |=> !data_switch_close)
		else $error("data switch closed in sleep");
	a_dce_open: assert property (dedicated_charger_emulation && !cfg_r[0] |=> !data_switch_close)
		else $error("data switch closed in dedicated charging");
	a_emu_open: assert property (emulating && !emu_profile_cdp && cfg_r[2] |=> !data_switch_close)
		else $error("data switch closed while emulating");
	a_active_close: assert property (state_r == usb_psw_pkg::P_ACTIVE && low_supply_ok && !emulating
		&& !dedicated_charger_emulation |=> data_switch_close)
		else $error("data switch open in active");
	a_trip_error: assert property (s_trip |=> s_err_off)
		else $error("trip did not enter error with switch off");
	a_clamp_fast: assert property (port_switch_on && overcurrent |=> current_clamp)
		else $error("overcurrent not clamped");
	a_limit_cap: assert property (current_limit_setting <= hw_limit_r)
		else $error("applied limit above strap limit");
	a_strap_hold: assert property (strap_done_r |=> $stable(hw_limit_r) && $stable(comm_bus_mode))
		else $error("strap decode changed after power-up");
	a_soft_run: assert property ($rose(port_power_enable_ctl) |=> soft_start_active [*2])
		else $error("soft start not running after enable");
	a_bypass_det: assert property (state_r == usb_psw_pkg::P_DETECT |=> bypass_limit_sel)
		else $error("bypass limit not selected in detect");
	a_cc_cdp: assert property (cdp_mode |=> constant_current_limiting)
		else $error("cdp without constant current");
	a_trip_dflt: assert property (!cdp_mode && !dcp_accepted && !profile_timeout_active
		|=> !constant_current_limiting)
		else $error("constant current without cause");
	a_alert_mask: assert property ($rose(alert_n_oe) |-> err_age_r >= MASK_CYCLES)
		else $error("alert before mask time");
	// alert trails the error state through the mask counter and its own register
	a_alert_err: assert property (alert_n_oe |-> !alert_n_out
		&& $past(state_r, 2) == usb_psw_pkg::P_ERROR)
		else $error("alert without error");
endmodule

// file: test/portable_device_model.sv
`timescale 1ns/1ps
// stands in for the attached handset; the bench decides when it plugs in and overloads
module portable_device_model (
	input  wire logic aclk,
	input  wire logic plug_req,
	input  wire logic load_req,
	output logic      attach_event,
	output logic      removal_event,
	output logic      overcurrent
);
	logic plug_r;

	// quiet until the bench acts
	initial
	begin
		plug_r = 1'b0;
		attach_event = 1'b0;
		removal_event = 1'b0;
		overcurrent = 1'b0;
	end

	// one-cycle plug pulses; draw stays under the limit unless an overload is asked for
	always @(posedge aclk)
	begin
		plug_r <= plug_req;
		attach_event <= plug_req & ~plug_r;
		removal_event <= ~plug_req & plug_r;
		overcurrent <= load_req;
	end
endmodule

// file: test/testbench.sv
`timescale 1ns/1ps
module testbench;
	localparam int unsigned RISE = 8;
	localparam int unsigned MASK = 16;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, low_supply_ok, port_power_enable_ctl;
	logic        sleep_req, detect_enable, attach_event, removal_event, emulating;
	logic        emu_profile_cdp, dedicated_charger_emulation, dcp_accepted, cdp_mode;
	logic        profile_timeout_active, vbus_discharging, overcurrent, data_switch_close;
	logic        port_switch_on, constant_current_limiting, bypass_limit_sel;
	logic        soft_start_active, current_clamp, comm_bus_mode, alert_n_out, alert_n_oe;
	logic        plug_req, load_req;
	logic [3:0]  awaddr, araddr, wstrb, limit_and_comm_strap;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp;
	logic [2:0]  current_limit_setting;
	int          bad_count, check_count;

	usb_port_switch_control #(.RISE_CYCLES(RISE), .MASK_CYCLES(MASK)) i_usb_port_switch_control (
		.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .limit_and_comm_strap, .low_supply_ok, .port_power_enable_ctl, .sleep_req,
		.detect_enable, .attach_event, .removal_event, .emulating, .emu_profile_cdp,
		.dedicated_charger_emulation, .dcp_accepted, .cdp_mode, .profile_timeout_active,
		.vbus_discharging, .overcurrent, .data_switch_close, .port_switch_on,
		.current_limit_setting, .constant_current_limiting, .bypass_limit_sel,
		.soft_start_active, .current_clamp, .comm_bus_mode, .alert_n_out, .alert_n_oe
	);

	portable_device_model i_portable_device_model (
		.aclk, .plug_req, .load_req, .attach_event, .removal_event, .overcurrent
	);

	// free-running 100 MHz clock
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// sample a little after the edge so that registered outputs have landed
	task automatic step(input int n);
		repeat (n) @(posedge aclk);
		#1;
	endtask

	// write: both channels offered together, each dropped once its ready is seen
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// no cycle count assumed; only the watchdog ends a stuck wait
		do
		begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		chk("bresp", 32'(bresp), 32'(er));
		bready <= 1'b0;
	endtask

	// read one word and compare the masked value
	task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] exp, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		chk("rresp", 32'(rresp), 32'(er));
		chk(n, rdata & m, exp);
		rready <= 1'b0;
	endtask

	task automatic power_up(input logic [3:0] s);
		@(posedge aclk);
		aresetn <= 1'b0;
		limit_and_comm_strap <= s;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
	endtask

	task automatic t_strap;
		for (int c = 0; c < 8; c++)
		begin
			power_up({c[0], c[2:0]});
			step(3);
			chk("hw limit", 32'(current_limit_setting), 32'(c[2:0]));
			chk("comm mode", 32'(comm_bus_mode), 32'(c[0]));
		end
		power_up(4'h9);
		step(2);
		@(posedge aclk);
		limit_and_comm_strap <= 4'h6;
		step(4);
		chk("held limit", 32'(current_limit_setting), 32'h1);
		rchk("limit reg", usb_psw_pkg::OFS_LIMIT, 32'h177, 32'h111, 2'h0);
		rchk("config", usb_psw_pkg::OFS_CONFIG, 32'hff, 32'h76, 2'h0);
		rchk("control", usb_psw_pkg::OFS_CONTROL, 32'hffffffff, 32'h0, 2'h2);
		axw(usb_psw_pkg::OFS_STATUS, 32'hff, 2'h0);
		axw(4'h2, 32'h0, 2'h2);
		// no sleep request and detect_enable low, so the block wakes straight into Active
		rchk("state", usb_psw_pkg::OFS_STATUS, 32'h3, 32'(usb_psw_pkg::P_ACTIVE), 2'h0);
	endtask

	task automatic t_limit;
		axw(usb_psw_pkg::OFS_CONFIG, 32'h56, 2'h0);
		step(3);
		chk("capped limit", 32'(current_limit_setting), 32'h1);
		axw(usb_psw_pkg::OFS_CONFIG, 32'h06, 2'h0);
		step(3);
		chk("bus limit", 32'(current_limit_setting), 32'h0);
		axw(usb_psw_pkg::OFS_CONFIG, 32'h76, 2'h0);
	endtask

	task automatic t_detect;
		@(posedge aclk);
		detect_enable <= 1'b1;
		port_power_enable_ctl <= 1'b1;
		step(RISE + 6);
		chk("soft idle", 32'(soft_start_active), 32'h0);
		chk("data switch", 32'(data_switch_close), 32'h0);
		chk("bypass", 32'(bypass_limit_sel), 32'h1);
		rchk("state", usb_psw_pkg::OFS_STATUS, 32'h3, 32'h1, 2'h0);
		@(posedge aclk);
		plug_req <= 1'b1;
		step(4);
		chk("soft on", 32'(soft_start_active), 32'h1);
		chk("data switch", 32'(data_switch_close), 32'h1);
		chk("port switch", 32'(port_switch_on), 32'h1);
		chk("bypass", 32'(bypass_limit_sel), 32'h0);
		step(RISE + 4);
		chk("soft done", 32'(soft_start_active), 32'h0);
	endtask

	// emulating, cdp profile, dedicated charger, supply ok, discharging
	task automatic dcase(input logic [4:0] v, input logic ed, input logic ep);
		@(posedge aclk);
		{emulating, emu_profile_cdp, dedicated_charger_emulation, low_supply_ok,
			vbus_discharging} <= v;
		step(4);
		chk("data switch", 32'(data_switch_close), 32'(ed));
		chk("port switch", 32'(port_switch_on), 32'(ep));
	endtask

	task automatic t_active;
		dcase(5'b00010, 1'b1, 1'b1);
		dcase(5'b10010, 1'b0, 1'b1);
		dcase(5'b11010, 1'b1, 1'b1);
		dcase(5'b00110, 1'b0, 1'b1);
		dcase(5'b00000, 1'b0, 1'b1);
		dcase(5'b00011, 1'b1, 1'b0);
		axw(usb_psw_pkg::OFS_CONFIG, 32'h77, 2'h0);
		dcase(5'b00110, 1'b1, 1'b1);
		axw(usb_psw_pkg::OFS_CONFIG, 32'h76, 2'h0);
		dcase(5'b00010, 1'b1, 1'b1);
	endtask

	// cdp mode, timed profile, dcp accepted
	task automatic mcase(input logic [2:0] v, input logic e);
		@(posedge aclk);
		{cdp_mode, profile_timeout_active, dcp_accepted} <= v;
		step(4);
		chk("cc mode", 32'(constant_current_limiting), 32'(e));
	endtask

	task automatic t_mode;
		mcase(3'b000, 1'b0);
		mcase(3'b100, 1'b1);
		mcase(3'b010, 1'b1);
		mcase(3'b001, 1'b1);
		mcase(3'b000, 1'b0);
	endtask

	// the only way out of Error is the clear bit; sleep held so Sleep stays visible
	task automatic clear_error;
		@(posedge aclk);
		load_req <= 1'b0;
		cdp_mode <= 1'b0;
		port_power_enable_ctl <= 1'b0;
		sleep_req <= 1'b1;
		axw(usb_psw_pkg::OFS_CONTROL, 32'h1, 2'h0);
		step(3);
		rchk("state", usb_psw_pkg::OFS_STATUS, 32'h3, 32'h0, 2'h0);
		chk("alert oe", 32'(alert_n_oe), 32'h0);
		chk("data switch", 32'(data_switch_close), 32'h0);
		@(posedge aclk);
		sleep_req <= 1'b0;
	endtask

	task automatic t_cc_fault;
		@(posedge aclk);
		cdp_mode <= 1'b1;
		load_req <= 1'b1;
		step(4);
		chk("clamp", 32'(current_clamp), 32'h1);
		chk("port switch", 32'(port_switch_on), 32'h1);
		step(MASK + 4);
		rchk("state", usb_psw_pkg::OFS_STATUS, 32'h3, 32'h3, 2'h0);
		step(MASK + 4);
		chk("alert oe", 32'(alert_n_oe), 32'h1);
		chk("alert level", 32'(alert_n_out), 32'h0);
		clear_error();
	endtask

	task automatic t_trip;
		@(posedge aclk);
		port_power_enable_ctl <= 1'b1;
		detect_enable <= 1'b0;
		step(RISE + 6);
		chk("port switch", 32'(port_switch_on), 32'h1);
		@(posedge aclk);
		load_req <= 1'b1;
		step(3);
		chk("port switch", 32'(port_switch_on), 32'h0);
		rchk("state", usb_psw_pkg::OFS_STATUS, 32'h3, 32'h3, 2'h0);
		chk("alert masked", 32'(alert_n_oe), 32'h0);
		step(MASK);
		chk("alert oe", 32'(alert_n_oe), 32'h1);
		clear_error();
		@(posedge aclk);
		plug_req <= 1'b0;
		step(3);
	endtask

	// cut a hang short well past the expected run length
	initial
	begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		summarize();
	end

	// time-zero values, then the scenarios in order
	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, sleep_req, detect_enable} = 8'h00;
		{emulating, emu_profile_cdp, dedicated_charger_emulation, dcp_accepted} = 4'h0;
		{cdp_mode, profile_timeout_active, vbus_discharging, plug_req, load_req} = 5'h00;
		port_power_enable_ctl = 1'b0;
		low_supply_ok = 1'b1;
		awaddr = 4'h0;
		araddr = 4'h0;
		wdata = 32'h0;
		wstrb = 4'hf;
		limit_and_comm_strap = 4'h9;
		bad_count = 0;
		check_count = 0;
		t_strap();
		t_limit();
		t_detect();
		t_active();
		t_mode();
		t_cc_fault();
		t_trip();
		summarize();
	end
endmodule
